/* rtl/trm_cfg.svh */
// Constants for the token ring MAC profile block.
// Assumes a 200 MHz pclk; offsets are APB byte addresses.
`ifndef TRM_CFG_SVH
`define TRM_CFG_SVH
`define TRM_CLK_HZ 200000000
`define TRM_LINK_BPS 4000000
`define TRM_BIT_CYCLES (`TRM_CLK_HZ / `TRM_LINK_BPS)
`define TRM_TRR_US 4000
`define TRM_THT_US 8900
`define TRM_TOP_MS 20
`define TRM_TVX_MS 10
`define TRM_TNT_US 2600
`define TRM_TAM_S 7
`define TRM_TSM_S 15
`define TRM_TRR_CYC (`TRM_TRR_US * (`TRM_CLK_HZ / 1000000))
`define TRM_THT_CYC (`TRM_THT_US * (`TRM_CLK_HZ / 1000000))
`define TRM_TOP_CYC (`TRM_TOP_MS * (`TRM_CLK_HZ / 1000))
`define TRM_TVX_CYC (`TRM_TVX_MS * (`TRM_CLK_HZ / 1000))
`define TRM_TNT_CYC (`TRM_TNT_US * (`TRM_CLK_HZ / 1000000))
`define TRM_TAM_CYC (64'd`TRM_TAM_S * 64'd`TRM_CLK_HZ)
`define TRM_TSM_CYC (64'd`TRM_TSM_S * 64'd`TRM_CLK_HZ)
`define TRM_AMP_PRIO 3'h7
`define TRM_ALL_STATIONS 48'hC000FFFFFFFF
`define TRM_INFO_MAX 4425
`define TRM_INFO_SUPPORT 2000
`define TRM_REG_CTRL 12'h000
`define TRM_REG_STATUS 12'h004
`define TRM_REG_MY_ADDR_LO 12'h008
`define TRM_REG_MY_ADDR_HI 12'h00C
`define TRM_REG_GROUP_LO 12'h010
`define TRM_REG_GROUP_HI 12'h014
`define TRM_REG_FUNC 12'h018
`define TRM_REG_TIMER_START 12'h01C
`define TRM_REG_FRAME_DA_LO 12'h020
`define TRM_REG_FRAME_DA_HI 12'h024
`define TRM_REG_SEND_LEN 12'h028
`define TRM_REG_SEND_FC 12'h02C
`define TRM_REG_RX_COUNT 12'h030
`define TRM_CTRL_ENABLE 0
`define TRM_CTRL_GROUP_EN 1
`define TRM_CTRL_FUNC_EN 2
`define TRM_CTRL_SEND_ALL 3
`define TRM_CTRL_AMP 4
`define TRM_CTRL_SEND 5
`define TRM_NUM_TIMERS 7
`endif

/* rtl/trm_pkg.sv */
// Types shared by the token ring MAC profile block.
// Assumes trm_cfg.svh for every numeric constant.
package trm_pkg;
    typedef enum logic [2:0] {
        TRM_TMR_TRR, TRM_TMR_THT, TRM_TMR_TOP, TRM_TMR_TVX,
        TRM_TMR_TNT, TRM_TMR_TAM, TRM_TMR_TSM
    } trm_timer_type;
    typedef enum logic [3:0] {
        TRM_TX_IDLE, TRM_TX_SD, TRM_TX_AC, TRM_TX_FC, TRM_TX_DA, TRM_TX_SA,
        TRM_TX_INFO, TRM_TX_FCS, TRM_TX_ED, TRM_TX_FS
    } trm_tx_state_type;
    typedef enum logic [2:0] {
        TRM_RX_IDLE, TRM_RX_HDR, TRM_RX_DA, TRM_RX_SA, TRM_RX_INFO
    } trm_rx_state_type;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } trm_octet_type;
endpackage

/* rtl/trm_mac.sv */
// Token ring MAC profile core: frame build and check, timers, APB registers.
// Assumes a serialiser/deserialiser outside that moves octets at the line rate.
//
// Summary of operation
// RQ1: Octet strobes paced to 4 Mbit/s.
// RQ2: Addresses are 48 bits everywhere.
// RQ3: Active monitor present frames carry priority seven.
// RQ4: All-stations address accepted and used for broadcast.
// RQ5: Return-to-repeat timer expires after 4 ms.
// RQ6: Token holding limited to 8.9 ms.
// RQ7: TOP timer loaded with 20 ms.
// RQ8: Valid-transmission timer expires 10 ms after restart.
// RQ9: No-token timer expires after 2.6 ms.
// RQ10: Active monitor timer period seven seconds.
// RQ11: Standby monitor timer timeout fifteen seconds.
// RQ12: Field order SD AC FC DA SA INFO FCS ED FS.
// RQ13: Info field above 4425 bytes refused.
// RQ14: Info fields of 1 to 2000+ bytes handled; tx_info_addr is 8 bits, so the transmit info fetch wraps every 256 bytes.
// RQ15: Group destination address matching supported.
// RQ16: Functional address matching optional for multicast.
// RQ17: Timers count pclk cycles, cleared on reset.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "trm_cfg.svh"
module trm_mac import trm_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit octets toward the ring
    output trm_octet_type tx_octet,
    output logic [7:0] tx_info_addr,
    input wire logic [7:0] tx_info_data,
    // Receive octets from the ring
    input wire trm_octet_type rx_octet,
    output logic rx_match,
    output logic rx_too_long,
    // Timer expiry levels
    output logic [`TRM_NUM_TIMERS-1:0] timer_expired
);
    localparam int BITCYC = `TRM_BIT_CYCLES * 8;
    logic [31:0] ctrl;
    logic [47:0] my_addr, group_addr, frame_da;
    logic [31:0] func_mask;
    logic [12:0] send_len;
    logic [7:0] send_fc;
    logic [15:0] rx_count;
    logic [35:0] tmr_cnt [`TRM_NUM_TIMERS];
    logic [`TRM_NUM_TIMERS-1:0] tmr_run, tmr_start;
    logic [35:0] tmr_limit [`TRM_NUM_TIMERS];
    logic send_pulse, send_busy;
    logic [9:0] pace;
    logic octet_tick;
    trm_tx_state_type tx_state;
    logic [12:0] tx_idx;
    trm_rx_state_type rx_state;
    logic [12:0] rx_idx;
    logic [47:0] rx_da;
    logic wr_en;
    logic rx_over;

    // Register address decode, used by write and read paths
    function automatic logic known_addr(input logic [11:0] a);
        return a <= `TRM_REG_RX_COUNT && a[1:0] == 2'h0;
    endfunction

    assign wr_en = psel && penable && pwrite && known_addr(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !known_addr(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 32'h0000_0000;
            my_addr <= 48'h0;
            group_addr <= 48'h0;
            func_mask <= 32'h0;
            frame_da <= 48'h0;
            send_len <= 13'h0001;
            send_fc <= 8'h00;
            tmr_start <= '0;
            send_pulse <= 1'b0;
        end else begin
            tmr_start <= '0;
            send_pulse <= 1'b0;
            if (wr_en) begin
                case (paddr)
                    `TRM_REG_CTRL: begin
                        ctrl <= {26'h0, 1'b0, pwdata[4:0]};
                        send_pulse <= pwdata[`TRM_CTRL_SEND];
                    end
                    `TRM_REG_MY_ADDR_LO: my_addr[31:0] <= pwdata;
                    `TRM_REG_MY_ADDR_HI: my_addr[47:32] <= pwdata[15:0];
                    `TRM_REG_GROUP_LO: group_addr[31:0] <= pwdata;
                    `TRM_REG_GROUP_HI: group_addr[47:32] <= pwdata[15:0];
                    `TRM_REG_FUNC: func_mask <= pwdata;
                    `TRM_REG_TIMER_START: tmr_start <= pwdata[`TRM_NUM_TIMERS-1:0];
                    `TRM_REG_FRAME_DA_LO: frame_da[31:0] <= pwdata;
                    `TRM_REG_FRAME_DA_HI: frame_da[47:32] <= pwdata[15:0];
                    `TRM_REG_SEND_LEN: send_len <= pwdata[12:0];
                    `TRM_REG_SEND_FC: send_fc <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `TRM_REG_CTRL: prdata <= ctrl;
                `TRM_REG_STATUS: prdata <= {16'h0, 7'h0, send_busy, 1'b0, timer_expired};
                `TRM_REG_MY_ADDR_LO: prdata <= my_addr[31:0];
                `TRM_REG_MY_ADDR_HI: prdata <= {16'h0, my_addr[47:32]};
                `TRM_REG_GROUP_LO: prdata <= group_addr[31:0];
                `TRM_REG_GROUP_HI: prdata <= {16'h0, group_addr[47:32]};
                `TRM_REG_FUNC: prdata <= func_mask;
                `TRM_REG_TIMER_START: prdata <= {25'h0, tmr_run};
                `TRM_REG_FRAME_DA_LO: prdata <= frame_da[31:0];
                `TRM_REG_FRAME_DA_HI: prdata <= {16'h0, frame_da[47:32]};
                `TRM_REG_SEND_LEN: prdata <= {19'h0, send_len};
                `TRM_REG_SEND_FC: prdata <= {24'h0, send_fc};
                `TRM_REG_RX_COUNT: prdata <= {16'h0, rx_count};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Protocol timers from pclk cycle counts
    assign tmr_limit[TRM_TMR_TRR] = 36'(`TRM_TRR_CYC); // [RQ5] [RQ17]
    assign tmr_limit[TRM_TMR_THT] = 36'(`TRM_THT_CYC); // [RQ6]
    assign tmr_limit[TRM_TMR_TOP] = 36'(`TRM_TOP_CYC); // [RQ7]
    assign tmr_limit[TRM_TMR_TVX] = 36'(`TRM_TVX_CYC); // [RQ8]
    assign tmr_limit[TRM_TMR_TNT] = 36'(`TRM_TNT_CYC); // [RQ9]
    assign tmr_limit[TRM_TMR_TAM] = 36'(`TRM_TAM_CYC); // [RQ10]
    assign tmr_limit[TRM_TMR_TSM] = 36'(`TRM_TSM_CYC); // [RQ11]

    for (genvar t = 0; t < `TRM_NUM_TIMERS; t++) begin : g_tmr
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tmr_cnt[t] <= 36'h0; // [RQ17]
                tmr_run[t] <= 1'b0;
                timer_expired[t] <= 1'b0;
            end else if (tmr_start[t]) begin
                tmr_cnt[t] <= 36'h0;
                tmr_run[t] <= 1'b1;
                timer_expired[t] <= 1'b0;
            end else if (tmr_run[t]) begin
                if (tmr_cnt[t] == tmr_limit[t] - 36'h1) begin
                    tmr_run[t] <= 1'b0;
                    timer_expired[t] <= 1'b1;
                end
                tmr_cnt[t] <= tmr_cnt[t] + 36'h1;
            end
        end
    end

    // Octet pacing at the line rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pace <= 10'h0;
        end else if (pace == 10'(BITCYC - 1)) begin
            pace <= 10'h0; // [RQ1]
        end else begin
            pace <= pace + 10'h1;
        end
    end
    assign octet_tick = pace == 10'(BITCYC - 1);
    assign send_busy = tx_state != TRM_TX_IDLE;
    assign tx_info_addr = tx_idx[7:0];
    // Info plus 6 trailer octets past the limit, judged on the current octet
    assign rx_over = rx_idx >= 13'(`TRM_INFO_MAX + 6);

    // Transmit sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TRM_TX_IDLE;
            tx_idx <= 13'h0;
            tx_octet <= '0;
        end else begin
            tx_octet.valid <= 1'b0;
            tx_octet.last <= 1'b0;
            case (tx_state)
                TRM_TX_IDLE: begin
                    // Lengths outside 1..4425 are refused
                    if (send_pulse && ctrl[`TRM_CTRL_ENABLE] && send_len != 13'h0
                        && send_len <= 13'(`TRM_INFO_MAX)) begin // [RQ13] [RQ14]
                        tx_state <= TRM_TX_SD;
                    end
                end
                default: if (octet_tick) begin
                    tx_octet.valid <= 1'b1;
                    tx_idx <= tx_idx + 13'h1;
                    case (tx_state)
                        TRM_TX_SD: begin
                            tx_octet.data <= 8'h00;
                            tx_state <= TRM_TX_AC; // [RQ12]
                            tx_idx <= 13'h0;
                        end
                        TRM_TX_AC: begin
                            // AC priority field in bits 7:5
                            tx_octet.data <= ctrl[`TRM_CTRL_AMP] ? {`TRM_AMP_PRIO, 5'h00}
                                : 8'h00; // [RQ3]
                            tx_state <= TRM_TX_FC;
                        end
                        TRM_TX_FC: begin
                            tx_octet.data <= send_fc;
                            tx_state <= TRM_TX_DA;
                            tx_idx <= 13'h0;
                        end
                        TRM_TX_DA: begin
                            tx_octet.data <= ctrl[`TRM_CTRL_SEND_ALL]
                                ? 8'(`TRM_ALL_STATIONS >> (8 * (5 - tx_idx[2:0]))) // [RQ4]
                                : 8'(frame_da >> (8 * (5 - tx_idx[2:0]))); // [RQ2]
                            if (tx_idx == 13'h5) begin
                                tx_state <= TRM_TX_SA;
                                tx_idx <= 13'h0;
                            end
                        end
                        TRM_TX_SA: begin
                            tx_octet.data <= 8'(my_addr >> (8 * (5 - tx_idx[2:0])));
                            if (tx_idx == 13'h5) begin
                                tx_state <= TRM_TX_INFO;
                                tx_idx <= 13'h0;
                            end
                        end
                        TRM_TX_INFO: begin
                            tx_octet.data <= tx_info_data;
                            if (tx_idx == send_len - 13'h1) begin
                                tx_state <= TRM_TX_FCS;
                                tx_idx <= 13'h0;
                            end
                        end
                        TRM_TX_FCS: begin
                            tx_octet.data <= 8'h00;
                            if (tx_idx == 13'h3) begin
                                tx_state <= TRM_TX_ED;
                            end
                        end
                        TRM_TX_ED: begin
                            tx_octet.data <= 8'h00;
                            tx_state <= TRM_TX_FS;
                        end
                        TRM_TX_FS: begin
                            tx_octet.data <= 8'h00;
                            tx_octet.last <= 1'b1;
                            tx_state <= TRM_TX_IDLE;
                        end
                        default: tx_state <= TRM_TX_IDLE;
                    endcase
                end
            endcase
        end
    end

    // Receive checker: destination match and info length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= TRM_RX_IDLE;
            rx_idx <= 13'h0;
            rx_da <= 48'h0;
            rx_match <= 1'b0;
            rx_too_long <= 1'b0;
            rx_count <= 16'h0;
        end else if (rx_octet.valid) begin
            rx_idx <= rx_idx + 13'h1;
            case (rx_state)
                TRM_RX_IDLE: begin
                    rx_state <= TRM_RX_HDR;
                    rx_idx <= 13'h1;
                    rx_match <= 1'b0;
                    rx_too_long <= 1'b0;
                end
                TRM_RX_HDR: if (rx_idx == 13'h2) begin
                    rx_state <= TRM_RX_DA;
                    rx_idx <= 13'h0;
                end
                TRM_RX_DA: begin
                    rx_da <= {rx_da[39:0], rx_octet.data}; // [RQ2]
                    if (rx_idx == 13'h5) begin
                        rx_state <= TRM_RX_SA;
                        rx_idx <= 13'h0;
                    end
                end
                TRM_RX_SA: begin
                    if (rx_idx == 13'h0) begin
                        rx_match <= ctrl[`TRM_CTRL_ENABLE] && (rx_da == my_addr
                            || rx_da == `TRM_ALL_STATIONS // [RQ4]
                            || (ctrl[`TRM_CTRL_GROUP_EN] && rx_da == group_addr) // [RQ15]
                            || (ctrl[`TRM_CTRL_FUNC_EN] && rx_da[47:31] == 17'h18000
                                && (rx_da[30:0] & func_mask[30:0]) != 31'h0)); // [RQ16]
                    end
                    if (rx_idx == 13'h5) begin
                        rx_state <= TRM_RX_INFO;
                        rx_idx <= 13'h0;
                    end
                end
                TRM_RX_INFO: begin
                    // Trailer of 6 octets follows info
                    if (rx_over) begin
                        rx_too_long <= 1'b1; // [RQ13]
                        rx_match <= 1'b0;
                    end
                    if (rx_octet.last) begin
                        rx_state <= TRM_RX_IDLE;
                        if (rx_match && !rx_too_long && !rx_over) begin
                            rx_count <= rx_count + 16'h1; // [RQ14]
                        end
                    end
                end
                default: rx_state <= TRM_RX_IDLE;
            endcase
        end
    end
endmodule // trm_mac

/* verification/trm_mac_properties.sv */
// Checker for trm_mac: octet pacing, frame layout, timer limits.
// Assumes binding to trm_mac; sees only that module's ports.
`timescale 1ns/10ps
`include "trm_cfg.svh"
module trm_mac_properties import trm_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Ring side
    input wire trm_octet_type tx_octet,
    input wire logic rx_match,
    input wire logic rx_too_long,
    input wire logic [`TRM_NUM_TIMERS-1:0] timer_expired
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic amp;
    logic all;
    logic [12:0] len;
    logic [12:0] idx;
    logic [15:0] gap;
    logic [31:0] tcnt [3];
    assign wr = psel && penable && pwrite && pready;
    // Frame position and the settings it was sent with
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp <= 1'b0;
            all <= 1'b0;
            len <= 13'h1;
            idx <= 13'h0;
            gap <= 16'h0;
        end else begin
            if (wr && paddr == `TRM_REG_CTRL && pwdata[`TRM_CTRL_SEND]) begin
                amp <= pwdata[`TRM_CTRL_AMP];
                all <= pwdata[`TRM_CTRL_SEND_ALL];
            end
            if (wr && paddr == `TRM_REG_SEND_LEN) begin
                len <= pwdata[12:0];
            end
            if (tx_octet.valid) begin
                idx <= tx_octet.last ? 13'h0 : idx + 13'h1;
            end
            gap <= tx_octet.valid ? 16'h0 : gap + 16'h1;
        end
    end
    // Cycles since start of TRR, THT and TNT
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt <= '{default: 32'h0};
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr && paddr == `TRM_REG_TIMER_START && pwdata[i == 2 ? 4 : i]) begin
                    tcnt[i] <= 32'h0;
                end else begin
                    tcnt[i] <= tcnt[i] + 32'h1;
                end
            end
        end
    end
    sequence s_fs;
        tx_octet.valid && tx_octet.last;
    endsequence
    a_octet_pace: assert property (tx_octet.valid && idx != 0 |-> gap == 8 * `TRM_BIT_CYCLES - 1)
        else $error("octet spacing wrong");
    a_frame_order: assert property (s_fs |-> idx == len + 13'd20)
        else $error("frame status octet misplaced");
    a_amp_prio: assert property (tx_octet.valid && idx == 1 && amp |-> tx_octet.data[7:5] == 3'h7)
        else $error("monitor frame priority wrong");
    a_bcast_da: assert property (tx_octet.valid && all && idx >= 3 && idx <= 8
        |-> tx_octet.data == 8'(`TRM_ALL_STATIONS >> (8 * (8 - idx)))) else $error("broadcast DA wrong");
    a_len_limit: assert property (tx_octet.valid && idx == 0 |-> len >= 1 && len <= 4425)
        else $error("frame sent with illegal length");
    a_long_drop: assert property ($rose(rx_too_long) |-> ##[0:1] !rx_match)
        else $error("long frame still matched");
    a_reset_clear: assert property ($rose(presetn) |-> timer_expired == '0 && !rx_too_long)
        else $error("state not cleared by reset");
    a_trr_limit: assert property ($rose(timer_expired[0])
        |-> tcnt[0] >= `TRM_TRR_CYC && tcnt[0] <= `TRM_TRR_CYC + 2) else $error("TRR period wrong");
    a_tht_limit: assert property ($rose(timer_expired[1])
        |-> tcnt[1] >= `TRM_THT_CYC && tcnt[1] <= `TRM_THT_CYC + 2) else $error("THT period wrong");
    a_tnt_limit: assert property ($rose(timer_expired[4])
        |-> tcnt[2] >= `TRM_TNT_CYC && tcnt[2] <= `TRM_TNT_CYC + 2) else $error("TNT period wrong");
endmodule // trm_mac_properties
bind trm_mac trm_mac_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .tx_octet(tx_octet), .rx_match(rx_match), .rx_too_long(rx_too_long),
    .timer_expired(timer_expired));

/* verification/trm_ring_station.sv */
// Far-side model: returns info bytes, records and sends ring octets.
// Assumes the bench calls send_frame and reads the seen queue.
`timescale 1ns/10ps
module trm_ring_station import trm_pkg::*; #(
    parameter int GAP = 4
) (
    // Clock
    input wire logic pclk,
    // Octets from the controller
    input wire trm_octet_type tx_octet,
    input wire logic [7:0] tx_info_addr,
    output logic [7:0] tx_info_data,
    // Octets toward the controller
    output trm_octet_type rx_octet
);
    logic [7:0] seen [$];
    assign tx_info_data = tx_info_addr ^ 8'h5A;
    initial rx_octet = '0;
    always @(posedge pclk) begin
        if (tx_octet.valid === 1'b1) begin
            seen.push_back(tx_octet.data);
        end
    end
    // Header, DA, SA, info, zero check field, end, status
    function automatic logic [7:0] octet_at(logic [47:0] da, int len, int i);
        if (i < 3) return 8'h10 + 8'(i);
        if (i < 9) return da[8 * (8 - i) +: 8];
        if (i < 15) return 8'h20 + 8'(i);
        if (i < 15 + len) return 8'(i);
        if (i < 19 + len) return 8'h00;
        return 8'hE0 + 8'(i);
    endfunction
    // Octet spacing shortened to keep long frames brief
    task automatic send_frame(input logic [47:0] da, input int len);
        for (int i = 0; i < len + 21; i++) begin
            @(posedge pclk);
            rx_octet <= '{valid: 1'b1, last: (i == len + 20), data: octet_at(da, len, i)};
            @(posedge pclk);
            rx_octet <= '{valid: 1'b0, last: 1'b0, data: ~octet_at(da, len, i)};
            repeat (GAP - 2) @(posedge pclk);
        end
    endtask
endmodule // trm_ring_station

/* verification/test_trm_mac.sv */
// Testbench for trm_mac: registers, frame send, frame receive.
// Assumes trm_ring_station on the ring side and the bound checker.
`timescale 1ns/10ps
`include "trm_cfg.svh"
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); end end
module test_trm_mac;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_match, rx_too_long, err;
    trm_pkg::trm_octet_type tx_octet, rx_octet;
    logic [7:0] tx_info_addr, tx_info_data;
    logic [`TRM_NUM_TIMERS-1:0] timer_expired;
    logic [31:0] rdv;
    int n_errors = 0;
    int cmp_count = 0;
    int cnt = 0;
    logic [47:0] my = 48'h4000_1234_5678;
    logic [47:0] rx_da [7] = '{48'hC000_FFFF_FFFF, 48'h4000_1234_5678, 48'h8000_0000_1234,
        48'hC000_0000_0010, 48'h4000_0000_0001, 48'h8000_0000_1234, 48'hC000_0000_0010};
    logic rx_hit [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    trm_mac dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_octet(tx_octet), .tx_info_addr(tx_info_addr),
        .tx_info_data(tx_info_data), .rx_octet(rx_octet), .rx_match(rx_match),
        .rx_too_long(rx_too_long), .timer_expired(timer_expired));
    trm_ring_station #(.GAP(4)) ring (.pclk(pclk), .tx_octet(tx_octet),
        .tx_info_addr(tx_info_addr), .tx_info_data(tx_info_data), .rx_octet(rx_octet));
    initial forever #2.5 pclk = ~pclk;
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            n_errors++;
            complete_run();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHECK(rdv, exp)
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 5000; n++) begin
            apb(1'b0, `TRM_REG_STATUS, 32'h0);
            if (rdv[8] === 1'b0) break;
        end
        if (n == 5000) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic chk_frame(input logic [47:0] da, input int len);
        `CHECK(ring.seen.size(), len + 21)
        for (int i = 0; i < 6; i++) begin
            `CHECK(ring.seen[3 + i], da[8 * (5 - i) +: 8])
            `CHECK(ring.seen[9 + i], my[8 * (5 - i) +: 8])
        end
        for (int i = 0; i < len + 4; i++) begin
            `CHECK(ring.seen[15 + i], i < len ? 8'(i) ^ 8'h5A : 8'h00)
        end
        ring.seen.delete();
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`TRM_REG_CTRL, 32'h0);
        rd_chk(`TRM_REG_SEND_LEN, 32'h1);
        rd_chk(`TRM_REG_RX_COUNT, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        `CHECK({err, rdv}, 33'h100000000)
        apb(1'b1, `TRM_REG_TIMER_START, 32'h1F);
        rd_chk(`TRM_REG_TIMER_START, 32'h1F);
        apb(1'b1, `TRM_REG_MY_ADDR_LO, 32'h12345678);
        apb(1'b1, `TRM_REG_MY_ADDR_HI, 32'hFFFF4000);
        rd_chk(`TRM_REG_MY_ADDR_HI, 32'h4000);
        apb(1'b1, `TRM_REG_GROUP_LO, 32'h1234);
        apb(1'b1, `TRM_REG_GROUP_HI, 32'h8000);
        apb(1'b1, `TRM_REG_FUNC, 32'h10);
        // Broadcast monitor frame, then addressed frame
        apb(1'b1, `TRM_REG_SEND_LEN, 32'd2);
        apb(1'b1, `TRM_REG_CTRL, 32'h39);
        wait_idle();
        `CHECK(ring.seen[1][7:5], 3'h7)
        chk_frame(`TRM_ALL_STATIONS, 2);
        apb(1'b1, `TRM_REG_FRAME_DA_LO, 32'hAABBCCDD);
        apb(1'b1, `TRM_REG_FRAME_DA_HI, 32'h0011);
        apb(1'b1, `TRM_REG_SEND_LEN, 32'd3);
        apb(1'b1, `TRM_REG_CTRL, 32'h21);
        wait_idle();
        chk_frame(48'h0011AABBCCDD, 3);
        // Illegal lengths are refused
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `TRM_REG_SEND_LEN, k == 0 ? 32'd0 : 32'd4426);
            apb(1'b1, `TRM_REG_CTRL, 32'h21);
            rd_chk(`TRM_REG_STATUS, 32'h0);
            repeat (800) @(posedge pclk);
            `CHECK(ring.seen.size(), 0)
        end
        // Address recognition with and without group and functional matching
        apb(1'b1, `TRM_REG_CTRL, 32'h07);
        for (int k = 0; k < 7; k++) begin
            if (k == 5) apb(1'b1, `TRM_REG_CTRL, 32'h01);
            ring.send_frame(rx_da[k], 1);
            cnt += rx_hit[k];
            rd_chk(`TRM_REG_RX_COUNT, 32'(cnt));
        end
        ring.send_frame(my, 4426);
        `CHECK(rx_too_long, 1'b1)
        `CHECK(rx_match, 1'b0)
        rd_chk(`TRM_REG_RX_COUNT, 32'(cnt));
        ring.send_frame(my, 4425);
        `CHECK(rx_too_long, 1'b0)
        rd_chk(`TRM_REG_RX_COUNT, 32'(cnt + 1));
        `CHECK(timer_expired, 7'h0)
        // Reset in mid-run clears the timers
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`TRM_REG_TIMER_START, 32'h0);
        `CHECK(timer_expired, 7'h0)
        complete_run();
    end
endmodule // test_trm_mac
